/* rsis_pkg.sv */
// Constants shared by the relay select and input scaling block
package rsis_pkg;
	// Width of the percent and speed quantities, tenths of a unit per LSB
	localparam int Q_W = 16;
	// Register byte addresses
	localparam logic [7:0] A_SCALE = 8'h00;
	localparam logic [7:0] A_OFS   = 8'h04;
	localparam logic [7:0] A_FUNC  = 8'h08;
	localparam logic [7:0] A_THR   = 8'h0C;
	localparam logic [7:0] A_HYST  = 8'h10;
	localparam logic [7:0] A_SRC   = 8'h14;
	localparam logic [7:0] A_MIN   = 8'h18;
	localparam logic [7:0] A_MAX   = 8'h1C;
	localparam logic [7:0] A_DISP  = 8'h20;
	localparam logic [7:0] A_SPEED = 8'h24;
	localparam logic [7:0] A_STAT  = 8'h28;
	// Legal ranges and reset values, 0.1 percent per LSB for scale, offset, threshold and hysteresis
	localparam logic [31:0]        SCALE_MAX = 32'h0000_4E20;
	localparam logic [15:0]        SCALE_RST = 16'h03E8;
	localparam logic signed [31:0] OFS_MIN   = -32'sh0000_1388;
	localparam logic signed [31:0] OFS_MAX   = 32'sh0000_1388;
	localparam logic [15:0]        OFS_RST   = 16'h0000;
	localparam logic [31:0]        FUNC_MAX  = 32'h0000_0009;
	localparam logic [3:0]         FUNC_RST  = 4'h1;
	localparam logic [31:0]        THR_MAX   = 32'h0000_07D0;
	localparam logic [15:0]        THR_RST   = 16'h03E8;
	localparam logic [31:0]        HYST_MAX  = 32'h0000_03E8;
	localparam logic [15:0]        HYST_RST  = 16'h0000;
	localparam logic [31:0]        SRC_MAX   = 32'h0000_000F;
	localparam logic [3:0]         SRC_SLAVE = 4'h9;
	localparam logic [3:0]         SRC_RST   = 4'h0;
	localparam logic [31:0]        SPD_MAX   = 32'h0000_FFFF;
	localparam logic [15:0]        MIN_RST   = 16'h0000;
	localparam logic [15:0]        MAX_RST   = 16'h01F4;
	// One hundred percent of the scaling factor
	localparam logic signed [34:0] PCT_UNITY = 35'sh0_0000_03E8;
	localparam logic [31:0]        SPD_UNITY = 32'h0000_03E8;
	// Relay function codes
	localparam logic [3:0] FN_RUN     = 4'h0;
	localparam logic [3:0] FN_HEALTHY = 4'h1;
	localparam logic [3:0] FN_AT_SPD  = 4'h2;
	localparam logic [3:0] FN_TRIP    = 4'h3;
	localparam logic [3:0] FN_FRQ_GE  = 4'h4;
	localparam logic [3:0] FN_CUR_GE  = 4'h5;
	localparam logic [3:0] FN_FRQ_LT  = 4'h6;
	localparam logic [3:0] FN_CUR_LT  = 4'h7;
	localparam logic [3:0] FN_AI2_GE  = 4'h8;
	localparam logic [3:0] FN_READY   = 4'h9;
	// Status register bit positions
	localparam int ST_RELAY = 0;
	localparam int ST_SLAVE = 1;
endpackage : rsis_pkg

/* rsis_thr_if.sv */
// Threshold and hysteresis carried to the comparators
`timescale 1ns/10ps
interface rsis_thr_if;
	logic [15:0] threshold;
	logic [15:0] hysteresis;
	modport src (output threshold, output hysteresis);
	modport sink (input threshold, input hysteresis);
endinterface : rsis_thr_if

/* rsis_hyst_cmp.sv */
// Threshold comparator with hysteresis, above or below sense
`timescale 1ns/10ps
module rsis_hyst_cmp
	import rsis_pkg::*;
#(
	parameter int W     = 16,
	parameter bit BELOW = 1'b0
) (
	input  wire logic         clock,
	input  wire logic         arst_n,
	rsis_thr_if.sink          thr,
	input  wire logic [W-1:0] quantity,
	output logic              active
);
	typedef struct packed {
		logic active;
	} rsis_cmp_s;

	rsis_cmp_s st_q;
	rsis_cmp_s st_d;
	logic [17:0] q_x;
	logic [17:0] t_x;
	logic [17:0] h_x;
	logic        hit;
	logic        release_c;

	// Quantity must fit the threshold width
	if (W < 1 || W > 16) begin : g_chk
		$error("rsis_hyst_cmp: W must be 1 to 16");
	end

	// Widened so that sums never wrap
	assign q_x = 18'(quantity);
	assign t_x = {2'b00, thr.threshold};
	assign h_x = {2'b00, thr.hysteresis};

	// Enter on crossing, leave only one hysteresis band back
	assign hit       = BELOW ? (q_x < t_x) : (q_x >= t_x);
	assign release_c = BELOW ? (q_x >= t_x + h_x) : (q_x + h_x < t_x);

	// Next state
	always_comb begin
		st_d = st_q;
		st_d.active = st_q.active ? !release_c : hit;
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign active = st_q.active;

	a_cmp_enter: assert property (@(posedge clock) disable iff (!arst_n)
		hit |=> active) else $error("comparator missed a crossing");
	a_cmp_band: assert property (@(posedge clock) disable iff (!arst_n)
		(active && !release_c) |=> active) else $error("comparator left inside band");
	a_cmp_leave: assert property (@(posedge clock) disable iff (!arst_n)
		(active && release_c) |=> !active) else $error("comparator stuck active");
endmodule : rsis_hyst_cmp

/* rsis_relay_scale.sv */
// Relay select and first analog input scaling, top level
//
// Overview of operation
// - Input level scaled by 0 to 2000 percent
// - Slave speed is master times factor, clamped
// - Signed offset from -500 to 500 percent
// - Display shows level minus offset, times factor
// - Selector 0 to 9, default 1, picks relay
// - Code 0: relay while drive running
// - Code 1: relay while powered, no fault
// - Code 2: relay while at setpoint frequency
// - Code 3: relay while drive tripped
// - Code 4: relay while frequency at/above threshold
// - Code 5: relay while current at/above threshold
// - Code 6: relay while frequency below threshold
// - Code 7: relay while current below threshold
// - Code 8: relay while input two at/above threshold
// - Code 9: relay while ready, no trip
// - Threshold 0 to 200 percent, default 100
// - Hysteresis 0 to 100 percent, default zero
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module rsis_relay_scale
	import rsis_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_we,
	input  wire logic               reg_re,
	output logic [31:0]             reg_rdata,
	input  wire logic [Q_W-1:0]     first_analog_input,
	input  wire logic [Q_W-1:0]     second_analog_input,
	input  wire logic [Q_W-1:0]     output_freq,
	input  wire logic [Q_W-1:0]     motor_current,
	input  wire logic [Q_W-1:0]     master_speed,
	input  wire logic               drive_running,
	input  wire logic               drive_powered,
	input  wire logic               drive_fault,
	input  wire logic               at_setpoint,
	input  wire logic               drive_ready,
	output logic                    relay_energise,
	output logic signed [31:0]      conditioned_input_display,
	output logic [Q_W-1:0]          slave_speed,
	output logic                    slave_mode
);
	typedef struct packed {
		logic [15:0] scale;
		logic [15:0] ofs;
		logic [3:0]  func;
		logic [15:0] thr;
		logic [15:0] hyst;
		logic [3:0]  src;
		logic [15:0] min_spd;
		logic [15:0] max_spd;
		logic [31:0] disp;
		logic [15:0] speed;
		logic        relay;
		logic [31:0] rdata;
	} rsis_main_s;

	localparam rsis_main_s RST = '{
		scale:   SCALE_RST,
		ofs:     OFS_RST,
		func:    FUNC_RST,
		thr:     THR_RST,
		hyst:    HYST_RST,
		src:     SRC_RST,
		min_spd: MIN_RST,
		max_spd: MAX_RST,
		disp:    32'h0000_0000,
		speed:   16'h0000,
		relay:   1'b0,
		rdata:   32'h0000_0000
	};

	rsis_main_s st_q;
	rsis_main_s st_d;

	logic signed [17:0] diff;
	logic signed [34:0] prod;
	logic signed [34:0] quo;
	logic [31:0]        m_prod;
	logic [31:0]        m_quo;
	logic [15:0]        m_clamp;
	logic               frq_ge;
	logic               cur_ge;
	logic               frq_lt;
	logic               cur_lt;
	logic               ai2_ge;
	logic               ofs_ok;
	logic               sel_relay;

	rsis_thr_if thr_bus ();

	// Comparators share one threshold and hysteresis setting
	assign thr_bus.threshold  = st_q.thr;
	assign thr_bus.hysteresis = st_q.hyst;

	// Output frequency at or above the threshold
	rsis_hyst_cmp #(
		.W     (Q_W),
		.BELOW (1'b0)
	) u_frq_ge (
		.clock    (clock),
		.arst_n   (arst_n),
		.thr      (thr_bus),
		.quantity (output_freq),
		.active   (frq_ge)
	);

	// Motor current at or above the threshold
	rsis_hyst_cmp #(
		.W     (Q_W),
		.BELOW (1'b0)
	) u_cur_ge (
		.clock    (clock),
		.arst_n   (arst_n),
		.thr      (thr_bus),
		.quantity (motor_current),
		.active   (cur_ge)
	);

	// Output frequency below the threshold
	rsis_hyst_cmp #(
		.W     (Q_W),
		.BELOW (1'b1)
	) u_frq_lt (
		.clock    (clock),
		.arst_n   (arst_n),
		.thr      (thr_bus),
		.quantity (output_freq),
		.active   (frq_lt)
	);

	// Motor current below the threshold
	rsis_hyst_cmp #(
		.W     (Q_W),
		.BELOW (1'b1)
	) u_cur_lt (
		.clock    (clock),
		.arst_n   (arst_n),
		.thr      (thr_bus),
		.quantity (motor_current),
		.active   (cur_lt)
	);

	// Second analog input at or above the threshold
	rsis_hyst_cmp #(
		.W     (Q_W),
		.BELOW (1'b0)
	) u_ai2_ge (
		.clock    (clock),
		.arst_n   (arst_n),
		.thr      (thr_bus),
		.quantity (second_analog_input),
		.active   (ai2_ge)
	);

	// Conditioned input: level minus offset, times the factor
	assign diff = $signed({2'b00, first_analog_input}) - $signed({{2{st_q.ofs[15]}}, st_q.ofs});
	// Operands widened first so the product is formed at full width
	assign prod = 35'(diff) * 35'($signed({1'b0, st_q.scale}));
	assign quo  = prod / PCT_UNITY; // Truncates toward zero

	// Slave speed: master times the same factor, then clamped
	assign m_prod = 32'(master_speed) * 32'(st_q.scale);
	assign m_quo  = m_prod / SPD_UNITY;

	// Maximum checked first, so an inverted pair yields the maximum above it and the minimum at or below it
	always_comb begin
		if (m_quo > 32'(st_q.max_spd)) begin
			m_clamp = st_q.max_spd;
		end else if (m_quo < 32'(st_q.min_spd)) begin
			m_clamp = st_q.min_spd;
		end else begin
			m_clamp = m_quo[15:0];
		end
	end

	// Relay condition for the selected function
	always_comb begin
		unique case (st_q.func)
			FN_RUN:     sel_relay = drive_running;
			FN_HEALTHY: sel_relay = drive_powered && !drive_fault;
			FN_AT_SPD:  sel_relay = at_setpoint;
			FN_TRIP:    sel_relay = drive_fault;
			FN_FRQ_GE:  sel_relay = frq_ge;
			FN_CUR_GE:  sel_relay = cur_ge;
			FN_FRQ_LT:  sel_relay = frq_lt;
			FN_CUR_LT:  sel_relay = cur_lt;
			FN_AI2_GE:  sel_relay = ai2_ge;
			FN_READY:   sel_relay = drive_ready && !drive_fault;
			default:    sel_relay = 1'b0;
		endcase
	end

	assign ofs_ok = ($signed(reg_wdata) >= OFS_MIN) && ($signed(reg_wdata) <= OFS_MAX);

	// Next state: register writes, reads and the computed outputs
	always_comb begin
		st_d = st_q;
		st_d.disp  = quo[31:0];
		st_d.speed = (st_q.src == SRC_SLAVE) ? m_clamp : 16'h0000;
		st_d.relay = sel_relay;
		st_d.rdata = 32'h0000_0000;
		// Out of range writes are dropped and the old value stays
		if (reg_we) begin
			unique case (reg_addr)
				A_SCALE: begin
					if (reg_wdata <= SCALE_MAX) begin
						st_d.scale = reg_wdata[15:0];
					end
				end
				A_OFS: begin
					if (ofs_ok) begin
						st_d.ofs = reg_wdata[15:0];
					end
				end
				A_FUNC: begin
					if (reg_wdata <= FUNC_MAX) begin
						st_d.func = reg_wdata[3:0];
					end
				end
				A_THR: begin
					if (reg_wdata <= THR_MAX) begin
						st_d.thr = reg_wdata[15:0];
					end
				end
				A_HYST: begin
					if (reg_wdata <= HYST_MAX) begin
						st_d.hyst = reg_wdata[15:0];
					end
				end
				A_SRC: begin
					if (reg_wdata <= SRC_MAX) begin
						st_d.src = reg_wdata[3:0];
					end
				end
				A_MIN: begin
					if (reg_wdata <= SPD_MAX) begin
						st_d.min_spd = reg_wdata[15:0];
					end
				end
				A_MAX: begin
					if (reg_wdata <= SPD_MAX) begin
						st_d.max_spd = reg_wdata[15:0];
					end
				end
				default: begin
				end
			endcase
		end
		// Read data stand for exactly the cycle after the strobe
		if (reg_re) begin
			unique case (reg_addr)
				A_SCALE: st_d.rdata = {16'h0000, st_q.scale};
				A_OFS:   st_d.rdata = {{16{st_q.ofs[15]}}, st_q.ofs};
				A_FUNC:  st_d.rdata = {28'h000_0000, st_q.func};
				A_THR:   st_d.rdata = {16'h0000, st_q.thr};
				A_HYST:  st_d.rdata = {16'h0000, st_q.hyst};
				A_SRC:   st_d.rdata = {28'h000_0000, st_q.src};
				A_MIN:   st_d.rdata = {16'h0000, st_q.min_spd};
				A_MAX:   st_d.rdata = {16'h0000, st_q.max_spd};
				A_DISP:  st_d.rdata = st_q.disp;
				A_SPEED: st_d.rdata = {16'h0000, st_q.speed};
				A_STAT: begin
					st_d.rdata[ST_RELAY] = st_q.relay;
					st_d.rdata[ST_SLAVE] = (st_q.src == SRC_SLAVE);
				end
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops, slave_mode decoded from the source flops
	assign reg_rdata                 = st_q.rdata;
	assign relay_energise            = st_q.relay;
	assign conditioned_input_display = $signed(st_q.disp);
	assign slave_speed               = st_q.speed;
	assign slave_mode                = (st_q.src == SRC_SLAVE);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	// Threshold code selected two cycles running, with a hit in the first of them
	sequence s_thr_hit(logic [3:0] code, logic hit);
		(st_q.func == code && hit) ##1 (st_q.func == code);
	endsequence

	property p_thr_relay(logic [3:0] code, logic hit);
		s_thr_hit(code, hit) |=> relay_energise;
	endproperty

	property p_direct(logic [3:0] code, logic cond);
		(st_q.func == code) |=> (relay_energise == $past(cond));
	endproperty

	a_scale_write: assert property (
		(reg_we && reg_addr == A_SCALE && reg_wdata <= SCALE_MAX)
		|=> st_q.scale == $past(reg_wdata[15:0])) else $error("scale write lost");
	a_scale_refuse: assert property (
		(reg_we && reg_addr == A_SCALE && reg_wdata > SCALE_MAX)
		|=> $stable(st_q.scale)) else $error("illegal scale accepted");
	a_slave_clamp: assert property (
		(st_q.src == SRC_SLAVE && st_q.min_spd <= st_q.max_spd)
		|=> (slave_speed >= $past(st_q.min_spd) && slave_speed <= $past(st_q.max_spd)))
		else $error("slave speed outside limits");
	a_ofs_range: assert property (
		$signed(st_q.ofs) >= -16'sh1388 && $signed(st_q.ofs) <= 16'sh1388)
		else $error("offset out of range");
	a_disp_zero: assert property (
		(first_analog_input == st_q.ofs && !st_q.ofs[15])
		|=> conditioned_input_display == 32'sh0000_0000) else $error("display not zero at offset");
	a_func_range: assert property (
		st_q.func <= FUNC_MAX[3:0]) else $error("relay code out of range");
	a_run_relay: assert property (p_direct(FN_RUN, drive_running))
		else $error("running relay wrong");
	a_healthy_relay: assert property (p_direct(FN_HEALTHY, drive_powered && !drive_fault))
		else $error("healthy relay wrong");
	a_atspd_relay: assert property (p_direct(FN_AT_SPD, at_setpoint))
		else $error("at speed relay wrong");
	a_trip_relay: assert property (p_direct(FN_TRIP, drive_fault))
		else $error("tripped relay wrong");
	a_frq_ge_relay: assert property (p_thr_relay(FN_FRQ_GE, output_freq >= st_q.thr))
		else $error("speed above limit relay missed");
	a_cur_ge_relay: assert property (p_thr_relay(FN_CUR_GE, motor_current >= st_q.thr))
		else $error("current above limit relay missed");
	a_frq_lt_relay: assert property (p_thr_relay(FN_FRQ_LT, output_freq < st_q.thr))
		else $error("speed below limit relay missed");
	a_cur_lt_relay: assert property (p_thr_relay(FN_CUR_LT, motor_current < st_q.thr))
		else $error("current below limit relay missed");
	a_ai2_relay: assert property (p_thr_relay(FN_AI2_GE, second_analog_input >= st_q.thr))
		else $error("input two relay missed");
	a_ready_relay: assert property (p_direct(FN_READY, drive_ready && !drive_fault))
		else $error("ready relay wrong");
	a_thr_range: assert property (
		32'(st_q.thr) <= THR_MAX) else $error("threshold out of range");
	a_hyst_range: assert property (
		32'(st_q.hyst) <= HYST_MAX) else $error("hysteresis out of range");
endmodule : rsis_relay_scale

/* rsis_relay_load.sv */
// Model of the external circuit wired across the relay contacts
`timescale 1ns/10ps
module rsis_relay_load (
	input  wire logic relay_energise,
	output logic      contact_closed
);
	// Coil pull-in is far below one clock period, so the contact follows the coil directly
	assign contact_closed = relay_energise;
endmodule : rsis_relay_load

/* rsis_relay_scale_tb.sv */
// Self-checking testbench for the relay select and input scaling block
`timescale 1ns/10ps
module rsis_relay_scale_tb;
	import rsis_pkg::*;
	logic              clock               = 1'b0;
	logic              arst_n              = 1'b0;
	logic [7:0]        reg_addr            = 8'h00;
	logic [31:0]       reg_wdata           = 32'h0000_0000;
	logic              reg_we              = 1'b0;
	logic              reg_re              = 1'b0;
	logic [31:0]       reg_rdata;
	logic [Q_W-1:0]    first_analog_input  = 16'h0000;
	logic [Q_W-1:0]    second_analog_input = 16'h0000;
	logic [Q_W-1:0]    output_freq         = 16'h0000;
	logic [Q_W-1:0]    motor_current       = 16'h0000;
	logic [Q_W-1:0]    master_speed        = 16'h0000;
	logic [4:0]        st                  = 5'h00;
	logic              relay_energise;
	logic signed [31:0] conditioned_input_display;
	logic [Q_W-1:0]    slave_speed;
	logic              slave_mode;
	logic              contact_closed;
	int                n_errors            = 0;
	int                n_tests             = 0;
	int                cyc                 = 0;

	// Free-running clock, 25 ns period
	always #12.5 clock = ~clock;

	rsis_relay_scale i_dut (
		.clock                     (clock),
		.arst_n                    (arst_n),
		.reg_addr                  (reg_addr),
		.reg_wdata                 (reg_wdata),
		.reg_we                    (reg_we),
		.reg_re                    (reg_re),
		.reg_rdata                 (reg_rdata),
		.first_analog_input        (first_analog_input),
		.second_analog_input       (second_analog_input),
		.output_freq               (output_freq),
		.motor_current             (motor_current),
		.master_speed              (master_speed),
		.drive_running             (st[0]),
		.drive_powered             (st[1]),
		.drive_fault               (st[2]),
		.at_setpoint               (st[3]),
		.drive_ready               (st[4]),
		.relay_energise            (relay_energise),
		.conditioned_input_display (conditioned_input_display),
		.slave_speed               (slave_speed),
		.slave_mode                (slave_mode)
	);

	rsis_relay_load i_load (
		.relay_energise (relay_energise),
		.contact_closed (contact_closed)
	);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_we <= 1'b0;
	endtask : wr

	// Read data is looked at in the single cycle it stands
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_re <= 1'b0;
		#1 chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask : rd

	task automatic settle();
		repeat (3) @(posedge clock);
		#1;
	endtask : settle

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// Expected relay level for the direct-status selector codes
	function automatic logic rel_exp(input logic [3:0] fn, input logic [4:0] s);
		case (fn)
			4'h0: return s[0];
			4'h1: return s[1] & ~s[2];
			4'h2: return s[3];
			4'h3: return s[2];
			default: return s[4] & ~s[2];
		endcase
	endfunction : rel_exp

	task automatic disp_case(input logic [31:0] sc, input logic [31:0] of, input logic [15:0] lvl);
		logic [31:0] e;
		wr(A_SCALE, sc);
		wr(A_OFS, of);
		first_analog_input <= lvl;
		settle();
		e = ((int'(lvl) - int'(signed'(of))) * int'(sc)) / 1000;
		chk("display", e, conditioned_input_display);
		rd(A_DISP, e);
	endtask : disp_case

	task automatic set_q(input logic [3:0] fn, input logic [15:0] v);
		case (fn)
			4'h4, 4'h6: output_freq <= v;
			4'h5, 4'h7: motor_current <= v;
			default: second_analog_input <= v;
		endcase
	endtask : set_q

	// Cuts a hung run short
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		logic [7:0]  ra [9];
		logic [31:0] rv [9];
		logic [3:0]  dc [5];
		logic [4:0]  pt [6];
		logic [15:0] qa [4];
		logic [15:0] qb [4];
		logic [15:0] ms [3];
		logic [15:0] se [3];
		ra = '{A_SCALE, A_OFS, A_FUNC, A_THR, A_HYST, A_SRC, A_MIN, A_MAX, 8'h40};
		rv = '{32'h3E8, 32'h0, 32'h1, 32'h3E8, 32'h0, 32'h0, 32'h0, 32'h1F4, 32'h0};
		dc = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
		pt = '{5'h00, 5'h1F, 5'h02, 5'h10, 5'h09, 5'h06};
		qa = '{16'h03E7, 16'h03E8, 16'h0384, 16'h0383};
		qb = '{16'h03E8, 16'h03E7, 16'h044B, 16'h044C};
		ms = '{16'h012C, 16'h001E, 16'h00C8};
		se = '{16'h01F4, 16'h0064, 16'h0190};
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		// Reset values and an unmapped read
		for (int i = 0; i < 9; i++) begin
			rd(ra[i], rv[i]);
		end
		chk("relay at reset", 32'h0, 32'(relay_energise));
		$display("test reset values done");
		// Offset, scaling and truncation toward zero
		disp_case(32'h7D0, 32'h64, 16'h01F4);
		disp_case(32'h5DC, 32'h0, 16'h0007);
		disp_case(32'h5DC, 32'hE, 16'h0007);
		disp_case(32'h4E20, 32'hFFFF_EC78, 16'h03E8);
		disp_case(32'h0, 32'h1388, 16'h0003);
		// Out-of-range writes leave registers unchanged
		wr(A_SCALE, 32'h4E21);
		rd(A_SCALE, 32'h0);
		wr(A_OFS, 32'h1389);
		wr(A_OFS, 32'hFFFF_EC77);
		rd(A_OFS, 32'h1388);
		wr(A_FUNC, 32'hA);
		rd(A_FUNC, 32'h1);
		wr(A_THR, 32'h7D1);
		wr(A_HYST, 32'h3E9);
		rd(A_THR, 32'h3E8);
		rd(A_HYST, 32'h0);
		$display("test input scaling done");
		// Slave speed clamped between minimum and maximum
		wr(A_SCALE, 32'h7D0);
		wr(A_MIN, 32'h64);
		wr(A_SRC, 32'h9);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			master_speed <= ms[i];
			settle();
			chk("slave speed", 32'(se[i]), 32'(slave_speed));
			chk("slave mode", 32'h1, 32'(slave_mode));
		end
		rd(A_SPEED, 32'h190);
		rd(A_STAT, 32'h2);
		wr(A_SRC, 32'h0);
		settle();
		chk("slave speed off", 32'h0, 32'(slave_speed));
		chk("slave mode off", 32'h0, 32'(slave_mode));
		$display("test slave speed done");
		// Direct status selector codes against six status patterns
		for (int c = 0; c < 5; c++) begin
			wr(A_FUNC, 32'(dc[c]));
			for (int p = 0; p < 6; p++) begin
				@(posedge clock);
				st <= pt[p];
				settle();
				chk($sformatf("relay code %0d", dc[c]), 32'(rel_exp(dc[c], pt[p])), 32'(relay_energise));
				chk("contact", 32'(rel_exp(dc[c], pt[p])), 32'(contact_closed));
			end
		end
		rd(A_STAT, 32'(rel_exp(4'h9, pt[5])));
		st <= 5'h00;
		$display("test direct codes done");
		// Threshold codes walked across both edges of the hysteresis band
		wr(A_THR, 32'h3E8);
		wr(A_HYST, 32'h64);
		for (int c = 4; c < 9; c++) begin
			wr(A_FUNC, 32'(c));
			set_q(4'(c), (c == 6 || c == 7) ? 16'h07D0 : 16'h0000);
			settle();
			for (int s = 0; s < 4; s++) begin
				@(posedge clock);
				set_q(4'(c), (c == 6 || c == 7) ? qb[s] : qa[s]);
				settle();
				chk($sformatf("relay code %0d step %0d", c, s), 32'(s == 1 || s == 2), 32'(relay_energise));
			end
		end
		$display("test threshold codes done");
		wrap_up();
	end
endmodule : rsis_relay_scale_tb
